// ---- common/shutdown_pkg.sv ----
// Purpose: shared constants and types for the output shutdown controller
// Assumes: AXI4-Lite register access, 8-bit byte addresses, 32-bit data
// Notes:   offsets are byte addresses of aligned words
package shutdown_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] MODE_OFS  = 8'h00;
	localparam logic [7:0] CTRL_OFS  = 8'h04;
	localparam logic [7:0] STAT_OFS  = 8'h08;
	localparam logic [7:0] SHORT_OFS = 8'h0C;
	localparam logic [7:0] MASK_OFS  = 8'h10;

	// ==========================================================
	// field layout
	localparam int N_REQ         = 5;
	localparam int N_PAIR        = 3;
	localparam int N_PHASE       = 6;
	localparam int N_STAT        = 7;
	localparam int MODE_EN_LSB   = 10;
	localparam int CTRL_SOFT_BIT = 0;
	localparam int CTRL_OSC_BIT  = 1;
	localparam int CTRL_PAIR_LSB = 2;
	localparam int CTRL_ALV_LSB  = 5;
	localparam int STAT_SHORT_BIT = 5;
	localparam int STAT_OSC_BIT  = 6;
	localparam int SHORT_FLAG_BIT = 0;

	// ==========================================================
	// reset values
	localparam logic [14:0] MODE_RST = 15'h0000;
	localparam logic [10:0] CTRL_RST = 11'h7E0;
	localparam logic [6:0]  MASK_RST = 7'h00;

	// ==========================================================
	// sampling timing
	localparam int          PRE_W        = 7;
	localparam logic [6:0]  DIV8_MASK    = 7'h07;
	localparam logic [6:0]  DIV16_MASK   = 7'h0F;
	localparam logic [6:0]  DIV128_MASK  = 7'h7F;
	localparam logic [3:0]  SAMPLE_LAST  = 4'hF;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		DET_EDGE   = 2'b00,
		DET_DIV8   = 2'b01,
		DET_DIV16  = 2'b10,
		DET_DIV128 = 2'b11
	} det_mode_e;

endpackage

// ---- src/req_detector.sv ----
// Purpose: falling-edge or sixteen-sample low detector for one request pin
// Assumes: pin_n_in already synchronised to clk_in
// Notes:   a held low level fires once; a high sample rearms it
`timescale 1ns/1ns
module req_detector
	import shutdown_pkg::*;
(
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	input  wire logic  ce_in,
	input  wire logic  pin_n_in,
	input  det_mode_e  mode_in,
	input  wire logic  tick8_in,
	input  wire logic  tick16_in,
	input  wire logic  tick128_in,
	output logic       detect_out
);

	logic       prev_reg;
	logic       prev_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic       done_reg;
	logic       done_next;
	logic       det_reg;
	logic       det_next;
	logic       tick;

	// ==========================================================
	// detection
	always_comb
	begin
		unique case (mode_in)
			DET_EDGE:   tick = 1'b0;
			DET_DIV8:   tick = tick8_in;
			DET_DIV16:  tick = tick16_in;
			DET_DIV128: tick = tick128_in;
		endcase
		prev_next = pin_n_in;
		cnt_next  = cnt_reg;
		done_next = done_reg;
		det_next  = 1'b0;
		if (mode_in == DET_EDGE)
		begin
			det_next  = prev_reg & ~pin_n_in;
			cnt_next  = 4'h0;
			done_next = 1'b0;
		end
		else if (pin_n_in)
		begin
			cnt_next  = 4'h0;
			done_next = 1'b0;
		end
		else if (tick && !done_reg)
		begin
			if (cnt_reg == SAMPLE_LAST)
			begin
				det_next  = 1'b1;
				done_next = 1'b1;
				cnt_next  = 4'h0;
			end
			else
			begin
				cnt_next = cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prev_reg <= 1'b1;
			cnt_reg  <= 4'h0;
			done_reg <= 1'b0;
			det_reg  <= 1'b0;
		end
		else if (ce_in)
		begin
			prev_reg <= prev_next;
			cnt_reg  <= cnt_next;
			done_reg <= done_next;
			det_reg  <= det_next;
		end
	end

	assign detect_out = det_reg;

	// ==========================================================
	// checks
	property p_edge_fire;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && mode_in == DET_EDGE && prev_reg && !pin_n_in) |=> detect_out;
	endproperty
	a_edge_fire: assert property (p_edge_fire) else $error("edge not detected");

	property p_low_fire;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && tick && !pin_n_in && !done_reg && cnt_reg == SAMPLE_LAST) |=> detect_out;
	endproperty
	a_low_fire: assert property (p_low_fire) else $error("low run not detected");

endmodule

// ---- src/output_shutdown_ctrl.sv ----
// Purpose: forces timer outputs to high impedance on fault, clock loss,
//          software request or complementary output short
// Assumes: phase inputs come from timer logic on SYS_CLK_IN
// Notes:   registers reached over AXI4-Lite
//
// What this block does
// - a fired request enabled in the mode register disables all target outputs.
// - an oscillator stop indication can disable all target outputs.
// - both phases of a pair active for a cycle disables complementary outputs.
// - a software control bit forces all target outputs to high impedance.
// - request detections and short comparison can raise the interrupt.
// - one short flag is set by any of the three pairs.
// - a pair with its enable bit cleared never sets the short flag.
// - each pair sets the flag only while its own enable bit is one.
// - short flag clears by writing zero after reading one, outputs inactive.
// - each phase pin has its own active level bit for comparison.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
module output_shutdown_ctrl
	import shutdown_pkg::*;
(
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        CE_IN,
	input  wire logic        FAULT_REQ_0_N_IN,
	input  wire logic        FAULT_REQ_4_N_IN,
	input  wire logic        FAULT_REQ_8_N_IN,
	input  wire logic        FAULT_REQ_10_N_IN,
	input  wire logic        FAULT_REQ_11_N_IN,
	input  wire logic        OSC_STOP_IN,
	input  wire logic        PHASE_OUT_3B_IN,
	input  wire logic        PHASE_OUT_3D_IN,
	input  wire logic        PHASE_OUT_4A_IN,
	input  wire logic        PHASE_OUT_4C_IN,
	input  wire logic        PHASE_OUT_4B_IN,
	input  wire logic        PHASE_OUT_4D_IN,
	output logic             TARGET_HIZ_OUT,
	output logic             COMP_HIZ_OUT,
	output logic             IRQ_OUT,
	input  wire logic [7:0]  S_AXI_AWADDR_IN,
	input  wire logic        S_AXI_AWVALID_IN,
	output logic             S_AXI_AWREADY_OUT,
	input  wire logic [31:0] S_AXI_WDATA_IN,
	input  wire logic [3:0]  S_AXI_WSTRB_IN,
	input  wire logic        S_AXI_WVALID_IN,
	output logic             S_AXI_WREADY_OUT,
	output logic [1:0]       S_AXI_BRESP_OUT,
	output logic             S_AXI_BVALID_OUT,
	input  wire logic        S_AXI_BREADY_IN,
	input  wire logic [7:0]  S_AXI_ARADDR_IN,
	input  wire logic        S_AXI_ARVALID_IN,
	output logic             S_AXI_ARREADY_OUT,
	output logic [31:0]      S_AXI_RDATA_OUT,
	output logic [1:0]       S_AXI_RRESP_OUT,
	output logic             S_AXI_RVALID_OUT,
	input  wire logic        S_AXI_RREADY_IN
);

	// ==========================================================
	// input synchronisers and prescaler
	logic [5:0]       sync1_reg;
	logic [5:0]       sync2_reg;
	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] pre_next;
	logic             tick8;
	logic             tick16;
	logic             tick128;
	logic [N_REQ-1:0] det;
	logic             osc_sync;

	always_comb
	begin
		pre_next = pre_reg + 7'h01;
		tick8    = (pre_reg & DIV8_MASK) == DIV8_MASK;
		tick16   = (pre_reg & DIV16_MASK) == DIV16_MASK;
		tick128  = (pre_reg & DIV128_MASK) == DIV128_MASK;
		osc_sync = sync2_reg[5];
	end

	// pins are asynchronous: first stage only feeds the second
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			sync1_reg <= 6'h1F;
			sync2_reg <= 6'h1F;
			pre_reg   <= 7'h00;
		end
		else if (CE_IN)
		begin
			sync1_reg <= {OSC_STOP_IN, FAULT_REQ_11_N_IN, FAULT_REQ_10_N_IN,
				FAULT_REQ_8_N_IN, FAULT_REQ_4_N_IN, FAULT_REQ_0_N_IN};
			sync2_reg <= sync1_reg;
			pre_reg   <= pre_next;
		end
	end

	// ==========================================================
	// request detectors
	logic [14:0] mode_reg;
	logic [14:0] mode_next;

	genvar gi;
	generate
		for (gi = 0; gi < N_REQ; gi++)
		begin : g_req
			req_detector req_detector_i
			(
				.clk_in     (SYS_CLK_IN),
				.rst_in     (RST_IN),
				.ce_in      (CE_IN),
				.pin_n_in   (sync2_reg[gi]),
				.mode_in    (det_mode_e'(mode_reg[2*gi +: 2])),
				.tick8_in   (tick8),
				.tick16_in  (tick16),
				.tick128_in (tick128),
				.detect_out (det[gi])
			);
		end
	endgenerate

	// ==========================================================
	// short comparison
	logic [10:0]        ctrl_reg;
	logic [10:0]        ctrl_next;
	logic [N_PHASE-1:0] phase;
	logic [N_PHASE-1:0] act;
	logic [N_PAIR-1:0]  pair_en;
	logic [N_PAIR-1:0]  pair_both;
	logic [N_PAIR-1:0]  short_evt;
	logic               short_set;

	always_comb
	begin
		phase   = {PHASE_OUT_4D_IN, PHASE_OUT_4B_IN, PHASE_OUT_4C_IN,
			PHASE_OUT_4A_IN, PHASE_OUT_3D_IN, PHASE_OUT_3B_IN};
		act     = ~(phase ^ ctrl_reg[CTRL_ALV_LSB +: N_PHASE]);
		pair_en = ctrl_reg[CTRL_PAIR_LSB +: N_PAIR];
		for (int p = 0; p < N_PAIR; p++)
		begin
			pair_both[p] = act[2*p] & act[2*p+1];
		end
		short_evt = pair_both & pair_en;
		short_set = |short_evt;
	end

	// ==========================================================
	// AXI4-Lite slave and registers
	logic              awready_reg;
	logic              awready_next;
	logic              wready_reg;
	logic              wready_next;
	logic              aw_held_reg;
	logic              aw_held_next;
	logic              w_held_reg;
	logic              w_held_next;
	logic [7:0]        awaddr_reg;
	logic [7:0]        awaddr_next;
	logic [31:0]       wdata_reg;
	logic [31:0]       wdata_next;
	logic [3:0]        wstrb_reg;
	logic [3:0]        wstrb_next;
	logic              bvalid_reg;
	logic              bvalid_next;
	logic [1:0]        bresp_reg;
	logic [1:0]        bresp_next;
	logic              arready_reg;
	logic              arready_next;
	logic              rvalid_reg;
	logic              rvalid_next;
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;
	logic [1:0]        rresp_reg;
	logic [1:0]        rresp_next;
	logic [N_STAT-1:0] stat_reg;
	logic [N_STAT-1:0] stat_next;
	logic [N_STAT-1:0] mask_reg;
	logic [N_STAT-1:0] mask_next;
	logic              short_flag_reg;
	logic              short_flag_next;
	logic              armed_reg;
	logic              armed_next;
	logic              target_hiz_reg;
	logic              target_hiz_next;
	logic              comp_hiz_reg;
	logic              comp_hiz_next;
	logic              irq_reg;
	logic              irq_next;
	logic              aw_take;
	logic              w_take;
	logic              do_wr;
	logic [7:0]        wa;
	logic [31:0]       wd;
	logic [31:0]       wm;
	logic [31:0]       wv;
	logic [N_STAT-1:0] events;
	logic [N_STAT-1:0] w1c;
	logic              short_clr;
	logic              hiz_all;

	always_comb
	begin
		aw_take = S_AXI_AWVALID_IN & awready_reg;
		w_take  = S_AXI_WVALID_IN & wready_reg;
		aw_held_next = aw_held_reg | aw_take;
		w_held_next  = w_held_reg | w_take;
		awaddr_next  = aw_take ? S_AXI_AWADDR_IN : awaddr_reg;
		wdata_next   = w_take ? S_AXI_WDATA_IN : wdata_reg;
		wstrb_next   = w_take ? S_AXI_WSTRB_IN : wstrb_reg;
		wa = awaddr_next;
		wd = wdata_next;
		wm = {{8{wstrb_next[3]}}, {8{wstrb_next[2]}}, {8{wstrb_next[1]}}, {8{wstrb_next[0]}}};
		do_wr = aw_held_next & w_held_next & ~bvalid_reg;
		bvalid_next = bvalid_reg & ~S_AXI_BREADY_IN;
		bresp_next  = bresp_reg;
		mode_next = mode_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		w1c       = '0;
		short_clr = 1'b0;
		armed_next = armed_reg;
		wv = 32'h0000_0000;
		if (do_wr)
		begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			unique case ({wa[7:2], 2'b00})
				MODE_OFS:
				begin
					wv = ({17'h0, mode_reg} & ~wm) | (wd & wm);
					mode_next = wv[14:0];
				end
				CTRL_OFS:
				begin
					wv = ({21'h0, ctrl_reg} & ~wm) | (wd & wm);
					ctrl_next = wv[10:0];
				end
				STAT_OFS:
				begin
					wv = wd & wm;
					w1c = wv[N_STAT-1:0];
				end
				SHORT_OFS:
				begin
					// clear only if armed by a read and every phase is inactive
					short_clr = wm[SHORT_FLAG_BIT] & ~wd[SHORT_FLAG_BIT]
						& armed_reg & ~(|act);
					armed_next = 1'b0;
				end
				MASK_OFS:
				begin
					wv = ({25'h0, mask_reg} & ~wm) | (wd & wm);
					mask_next = wv[N_STAT-1:0];
				end
				default:
				begin
					bresp_next = RESP_SLVERR;
				end
			endcase
		end
		awready_next = ~aw_held_next & ~bvalid_next;
		wready_next  = ~w_held_next & ~bvalid_next;

		rvalid_next = rvalid_reg & ~S_AXI_RREADY_IN;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (S_AXI_ARVALID_IN && arready_reg)
		begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			unique case ({S_AXI_ARADDR_IN[7:2], 2'b00})
				MODE_OFS:  rdata_next = {17'h0, mode_reg};
				CTRL_OFS:  rdata_next = {21'h0, ctrl_reg};
				STAT_OFS:  rdata_next = {25'h0, stat_reg};
				SHORT_OFS:
				begin
					rdata_next = {31'h0, short_flag_reg};
					armed_next = armed_next | short_flag_reg;
				end
				MASK_OFS:  rdata_next = {25'h0, mask_reg};
				default:
				begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
		arready_next = ~rvalid_next;

		// set wins over any clear in the same cycle
		short_flag_next = short_set | (short_flag_reg & ~short_clr);
		events = {osc_sync, short_set, det};
		stat_next = events | (stat_reg & ~w1c);
		irq_next  = |(stat_reg & mask_reg);

		hiz_all = ctrl_reg[CTRL_SOFT_BIT]
			| (ctrl_reg[CTRL_OSC_BIT] & osc_sync)
			| (|(stat_reg[N_REQ-1:0] & mode_reg[MODE_EN_LSB +: N_REQ]));
		target_hiz_next = hiz_all;
		comp_hiz_next   = hiz_all | short_flag_reg;
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			awready_reg    <= 1'b1;
			wready_reg     <= 1'b1;
			aw_held_reg    <= 1'b0;
			w_held_reg     <= 1'b0;
			awaddr_reg     <= 8'h00;
			wdata_reg      <= 32'h0000_0000;
			wstrb_reg      <= 4'h0;
			bvalid_reg     <= 1'b0;
			bresp_reg      <= RESP_OKAY;
			arready_reg    <= 1'b1;
			rvalid_reg     <= 1'b0;
			rdata_reg      <= 32'h0000_0000;
			rresp_reg      <= RESP_OKAY;
			mode_reg       <= MODE_RST;
			ctrl_reg       <= CTRL_RST;
			mask_reg       <= MASK_RST;
			stat_reg       <= '0;
			short_flag_reg <= 1'b0;
			armed_reg      <= 1'b0;
			target_hiz_reg <= 1'b0;
			comp_hiz_reg   <= 1'b0;
			irq_reg        <= 1'b0;
		end
		else if (CE_IN)
		begin
			awready_reg    <= awready_next;
			wready_reg     <= wready_next;
			aw_held_reg    <= aw_held_next;
			w_held_reg     <= w_held_next;
			awaddr_reg     <= awaddr_next;
			wdata_reg      <= wdata_next;
			wstrb_reg      <= wstrb_next;
			bvalid_reg     <= bvalid_next;
			bresp_reg      <= bresp_next;
			arready_reg    <= arready_next;
			rvalid_reg     <= rvalid_next;
			rdata_reg      <= rdata_next;
			rresp_reg      <= rresp_next;
			mode_reg       <= mode_next;
			ctrl_reg       <= ctrl_next;
			mask_reg       <= mask_next;
			stat_reg       <= stat_next;
			short_flag_reg <= short_flag_next;
			armed_reg      <= armed_next;
			target_hiz_reg <= target_hiz_next;
			comp_hiz_reg   <= comp_hiz_next;
			irq_reg        <= irq_next;
		end
	end

	assign S_AXI_AWREADY_OUT = awready_reg;
	assign S_AXI_WREADY_OUT  = wready_reg;
	assign S_AXI_BVALID_OUT  = bvalid_reg;
	assign S_AXI_BRESP_OUT   = bresp_reg;
	assign S_AXI_ARREADY_OUT = arready_reg;
	assign S_AXI_RVALID_OUT  = rvalid_reg;
	assign S_AXI_RDATA_OUT   = rdata_reg;
	assign S_AXI_RRESP_OUT   = rresp_reg;
	assign TARGET_HIZ_OUT    = target_hiz_reg;
	assign COMP_HIZ_OUT      = comp_hiz_reg;
	assign IRQ_OUT           = irq_reg;

	// ==========================================================
	// checks
	property p_short_set;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && |short_evt) |=> short_flag_reg;
	endproperty
	a_short_set: assert property (p_short_set) else $error("short flag missed");

	property p_short_gated;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && !short_flag_reg && (pair_both & pair_en) == 3'h0) |=> !short_flag_reg;
	endproperty
	a_short_gated: assert property (p_short_gated) else $error("disabled pair set flag");

	property p_comp_hiz;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && |short_evt) ##1 CE_IN |=> COMP_HIZ_OUT;
	endproperty
	a_comp_hiz: assert property (p_comp_hiz) else $error("short did not disable outputs");

	property p_soft_hiz;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && ctrl_reg[CTRL_SOFT_BIT]) |=> (TARGET_HIZ_OUT && COMP_HIZ_OUT);
	endproperty
	a_soft_hiz: assert property (p_soft_hiz) else $error("software force ignored");

	property p_osc_hiz;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && ctrl_reg[CTRL_OSC_BIT] && osc_sync) |=> TARGET_HIZ_OUT;
	endproperty
	a_osc_hiz: assert property (p_osc_hiz) else $error("oscillator stop ignored");

	property p_req_hiz;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && |(det & mode_reg[MODE_EN_LSB +: N_REQ]) && mode_next == mode_reg)
			##1 (CE_IN && w1c == '0) |=> TARGET_HIZ_OUT;
	endproperty
	a_req_hiz: assert property (p_req_hiz) else $error("request did not disable outputs");

	property p_clear_blocked;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && short_flag_reg && |act) |=> short_flag_reg;
	endproperty
	a_clear_blocked: assert property (p_clear_blocked) else $error("flag cleared while active");

	property p_irq;
		@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(CE_IN && |(stat_reg & mask_reg)) |=> IRQ_OUT;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// ---- verification/pwm_stage_model.sv ----
// Purpose: timer output stage and fault pin model facing the shutdown block
// Assumes: same clock as the block; phases come from timer flops
// Notes:   idle phases sit at their inactive level; request pins have pull-ups
`timescale 1ns/1ns
module pwm_stage_model
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [5:0] alv_in,
	input  wire logic [2:0] short_in,
	input  wire logic [4:0] req_low_in,
	output logic [5:0]      phase_out,
	output logic [4:0]      req_n_out
);
	// ==========================================
	// phase outputs, order 3B 3D 4A 4C 4B 4D
	logic [5:0] phase_next;

	always_comb
	begin
		for (int k = 0; k < 6; k++)
			phase_next[k] = short_in[k / 2] ? alv_in[k] : ~alv_in[k];
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			phase_out <= 6'h00;
		else
			phase_out <= phase_next;
	end

	// ==========================================
	// request pins: released pins float up
	assign req_n_out = ~req_low_in;
endmodule

// ---- verification/output_shutdown_ctrl_tb.sv ----
// Purpose: register-level bench for the output shutdown controller
// Assumes: AXI4-Lite master tasks; timer stage from pwm_stage_model
// Notes:   low sampling waits leave a tick of slack for the free prescaler
`timescale 1ns/1ns
module output_shutdown_ctrl_tb
	import shutdown_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        ce;
	logic        osc;
	logic [5:0]  alv;
	logic [5:0]  phase;
	logic [2:0]  shrt;
	logic [4:0]  req_low;
	logic [4:0]  req_n;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        hiz_t, hiz_c, irq;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;
	int          div;

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	output_shutdown_ctrl output_shutdown_ctrl_i
	(
		.SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
		.FAULT_REQ_0_N_IN(req_n[0]), .FAULT_REQ_4_N_IN(req_n[1]), .FAULT_REQ_8_N_IN(req_n[2]),
		.FAULT_REQ_10_N_IN(req_n[3]), .FAULT_REQ_11_N_IN(req_n[4]), .OSC_STOP_IN(osc),
		.PHASE_OUT_3B_IN(phase[0]), .PHASE_OUT_3D_IN(phase[1]), .PHASE_OUT_4A_IN(phase[2]),
		.PHASE_OUT_4C_IN(phase[3]), .PHASE_OUT_4B_IN(phase[4]), .PHASE_OUT_4D_IN(phase[5]),
		.TARGET_HIZ_OUT(hiz_t), .COMP_HIZ_OUT(hiz_c), .IRQ_OUT(irq),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready)
	);

	pwm_stage_model pwm_stage_model_i
	(
		.clk_in(clk), .rst_in(rst), .alv_in(alv), .short_in(shrt),
		.req_low_in(req_low), .phase_out(phase), .req_n_out(req_n)
	);

	// ==========================================
	// checking and bus tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic ochk(input string name, input logic seen, input logic exp);
		chk(name, {31'h0, seen}, {31'h0, exp});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		ochk("bvalid", bvalid, 1'b1);
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		@(posedge clk);
	endtask

	// one edge passes after each handshake so valid never drops and rises in one step
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		ochk("rvalid", rvalid, 1'b1);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		@(posedge clk);
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		axi_rd(a, RESP_OKAY, v);
		chk(name, v, exp);
	endtask

	task automatic end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// hang guard, well above the longest run
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			end_sim();
		end
	end

	// ==========================================
	// test sequence
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		osc = 1'b0;
		alv = 6'h3F;
		shrt = 3'h0;
		req_low = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		idle(20);
		rst <= 1'b0;
		idle(1);
		rchk("mode", MODE_OFS, 32'h0);
		rchk("ctrl", CTRL_OFS, 32'h7E0);
		rchk("stat", STAT_OFS, 32'h0);
		rchk("short", SHORT_OFS, 32'h0);
		rchk("mask", MASK_OFS, 32'h0);
		axi_rd(8'h14, RESP_SLVERR, rd);
		chk("unmapped", rd, 32'h0);
		axi_wr(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
		wstrb <= 4'h1;
		axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
		wstrb <= 4'hF;
		rchk("strobe", CTRL_OFS, 32'h700);
		axi_wr(CTRL_OFS, 32'h7E1, RESP_OKAY);
		idle(4);
		ochk("soft_t", hiz_t, 1'b1);
		ochk("soft_c", hiz_c, 1'b1);
		axi_wr(CTRL_OFS, 32'h7E0, RESP_OKAY);
		idle(4);
		ochk("soft_off", hiz_t, 1'b0);
		axi_wr(CTRL_OFS, 32'h7E2, RESP_OKAY);
		osc <= 1'b1;
		idle(6);
		ochk("osc_t", hiz_t, 1'b1);
		ochk("irq_masked", irq, 1'b0);
		axi_wr(MASK_OFS, 32'h40, RESP_OKAY);
		idle(2);
		ochk("irq_on", irq, 1'b1);
		osc <= 1'b0;
		idle(4);
		axi_wr(STAT_OFS, 32'h40, RESP_OKAY);
		rchk("osc_clr", STAT_OFS, 32'h0);
		ochk("irq_off", irq, 1'b0);
		axi_wr(CTRL_OFS, 32'h7E0, RESP_OKAY);
		axi_wr(MODE_OFS, 32'h7C00, RESP_OKAY);
		for (int i = 0; i < 5; i++)
		begin
			req_low <= 5'h01 << i;
			idle(8);
			ochk("req_hiz", hiz_t, 1'b1);
			rchk("req_stat", STAT_OFS, 32'h1 << i);
			req_low <= 5'h00;
			axi_wr(STAT_OFS, 32'h1 << i, RESP_OKAY);
			idle(3);
			ochk("req_rel", hiz_t, 1'b0);
		end
		for (int m = 1; m < 4; m++)
		begin
			div = (m == 1) ? 8 : (m == 2) ? 16 : 128;
			axi_wr(MODE_OFS, 32'h400 | m, RESP_OKAY);
			req_low <= 5'h01;
			idle(13 * div);
			req_low <= 5'h00;
			idle(2 * div);
			req_low <= 5'h01;
			idle(13 * div);
			rchk("low_short", STAT_OFS, 32'h0);
			idle(5 * div);
			rchk("low_fire", STAT_OFS, 32'h1);
			req_low <= 5'h00;
			idle(2 * div);
			axi_wr(STAT_OFS, 32'h1, RESP_OKAY);
		end
		axi_wr(MASK_OFS, 32'h20, RESP_OKAY);
		for (int p = 0; p < 3; p++)
		begin
			axi_wr(CTRL_OFS, 32'h7E0 | (32'h1C & ~(32'h4 << p)), RESP_OKAY);
			shrt <= 3'h1 << p;
			idle(4);
			rchk("off_flag", SHORT_OFS, 32'h0);
			axi_wr(CTRL_OFS, 32'h7E0 | (32'h4 << p), RESP_OKAY);
			idle(3);
			ochk("comp_hiz", hiz_c, 1'b1);
			ochk("tgt_hiz", hiz_t, 1'b0);
			ochk("short_irq", irq, 1'b1);
			rchk("flag", SHORT_OFS, 32'h1);
			axi_wr(SHORT_OFS, 32'h0, RESP_OKAY);
			shrt <= 3'h0;
			idle(2);
			axi_wr(SHORT_OFS, 32'h0, RESP_OKAY);
			rchk("flag_held", SHORT_OFS, 32'h1);
			axi_wr(SHORT_OFS, 32'h0, RESP_OKAY);
			rchk("flag_clr", SHORT_OFS, 32'h0);
			rchk("stat_short", STAT_OFS, 32'h20);
			axi_wr(STAT_OFS, 32'h20, RESP_OKAY);
			axi_wr(CTRL_OFS, 32'h7E0, RESP_OKAY);
			idle(2);
			ochk("comp_rel", hiz_c, 1'b0);
		end
		// frozen clock enable: an oscillator pulse inside it must leave no trace
		ce <= 1'b0;
		osc <= 1'b1;
		idle(6);
		ce <= 1'b1;
		osc <= 1'b0;
		idle(4);
		rchk("ce_hold", STAT_OFS, 32'h0);
		alv <= 6'h3C;
		axi_wr(CTRL_OFS, 32'h784, RESP_OKAY);
		idle(3);
		ochk("alv_idle", hiz_c, 1'b0);
		shrt <= 3'h1;
		idle(3);
		rchk("alv_flag", SHORT_OFS, 32'h1);
		end_sim();
	end
endmodule
